// ==== core/spcg_pkg.sv ====
// spcg_pkg: constants, types and helpers for the sleep port clock gating block
// assumes one system clock, synchronous active-high reset, and a plain register port
//
// Summary of operation
// RULE_01: each enable bit clocks its port when set; clear leaves port unclocked, disabled.
// RULE_02: access to a port whose clock is gated off returns a bus fault.
// RULE_03: register resets to zero, so every port starts unclocked.
// RULE_04: sleep enables apply in sleep only; run and deep-sleep use their own. Deep-sleep uses run enables while auto gating select is clear.
// RULE_05: sleep enables take effect only while the auto gating select bit is set.
// RULE_06: bits 7 down to 0 enable ports H down to A, all read/write.
// RULE_07: bits 31:8 are reserved, read zero; software preserves them on updates.
// RULE_08: register sits at offset 0x118 and is 32 bits wide.
// RULE_09: enable changes reach the ports through a glitch-free clock gate.
package spcg_pkg;

  // ----------------------------------------------------------------
  // widths and register map
  // ----------------------------------------------------------------
  localparam int SPCG_ADDR_W = 12;
  localparam int SPCG_DATA_W = 32;
  localparam int SPCG_PORTS = 8;
  localparam logic [11:0] SPCG_SLEEP_GATE_OFS = 12'h118;
  localparam logic [11:0] SPCG_IRQ_STATUS_OFS = 12'h200;
  localparam logic [11:0] SPCG_IRQ_CLEAR_OFS = 12'h204;
  localparam logic [11:0] SPCG_IRQ_ENABLE_OFS = 12'h208;
  localparam logic [11:0] SPCG_GATE_STATE_OFS = 12'h20C;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int SPCG_GATE_LSB = 0;
  localparam int SPCG_GATE_MSB = 7;
  localparam logic [7:0] SPCG_GATE_RESET = 8'h00;
  localparam int SPCG_EVT_MODE_BIT = 8;
  localparam int SPCG_EVT_W = 9;
  localparam logic [8:0] SPCG_EVT_RESET = 9'h000;
  localparam int SPCG_STATE_LSB = 8;
  localparam logic [31:0] SPCG_RDATA_RESET = 32'h00000000;

  // ----------------------------------------------------------------
  // power modes, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SPCG_RUN = 3'b001,
    SPCG_SLEEP = 3'b010,
    SPCG_DEEP = 3'b100
  } spcg_mode_t;

  // address match used by every register decode
  function automatic logic spcg_hit(input logic [11:0] addr, input logic [11:0] ofs);
    return addr == ofs;
  endfunction : spcg_hit

endpackage : spcg_pkg

// ==== core/spcg_gate_if.sv ====
// spcg_gate_if: enables and gated clocks passed between the core and its helpers
// assumes the core drives mode, auto gating select, source and applied enables, helpers return the rest
interface spcg_gate_if #(parameter int N = 8);
  import spcg_pkg::*;
  logic [N-1:0] run_gates;
  logic [N-1:0] sleep_gates;
  logic [N-1:0] deep_gates;
  logic [N-1:0] effective;
  logic [N-1:0] enables;
  logic [N-1:0] gated_clk;
  spcg_mode_t mode;
  logic auto_sel;
  modport core (output run_gates, sleep_gates, deep_gates, mode, auto_sel, enables,
                input effective, gated_clk);
  modport sel (input run_gates, sleep_gates, deep_gates, mode, auto_sel, output effective);
  modport gate (input enables, output gated_clk);
endinterface : spcg_gate_if

// ==== core/spcg_mode_select.sv ====
// spcg_mode_select: picks the enable set that applies in the present power mode
// assumes mode and the sleep source are stable flops of the core; run and deep-sleep sources are core inputs
module spcg_mode_select (
  spcg_gate_if.sel gif
);
  import spcg_pkg::*;

  // mode-dependent source; sleep set only when auto gating is selected
  always_comb begin
    case (gif.mode)
      SPCG_RUN: gif.effective = gif.run_gates; // [RULE_04]
      SPCG_SLEEP: gif.effective = gif.auto_sel ? gif.sleep_gates : gif.run_gates; // [RULE_04] [RULE_05]
      SPCG_DEEP: gif.effective = gif.auto_sel ? gif.deep_gates : gif.run_gates; // [RULE_04]
      default: gif.effective = gif.run_gates;
    endcase
  end

endmodule : spcg_mode_select

// ==== core/spcg_clock_gate_bank.sv ====
// spcg_clock_gate_bank: one glitch-free clock gate per port
// assumes enables come from flops clocked on the rising edge
module spcg_clock_gate_bank #(
  parameter int N = 8
) (
  input wire logic clock,
  input wire logic sys_rst,
  spcg_gate_if.gate gif
);
  import spcg_pkg::*;

  logic [N-1:0] en_low;

  // enable retimed while clock is low, so a change never cuts a high phase
  always_ff @(negedge clock) begin
    if (sys_rst) begin
      en_low <= '0;
    end else begin
      en_low <= gif.enables; // [RULE_09]
    end
  end

  // gated clocks, quiet while their enable is clear
  assign gif.gated_clk = {N{clock}} & en_low; // [RULE_01] [RULE_09]

endmodule : spcg_clock_gate_bank

// ==== core/spcg_core.sv ====
// spcg_core: sleep port clock gating register, mode tracking, faults and interrupt
// assumes a plain register port with read data one cycle after the read strobe,
// and a bus fabric that flags each port access with a one-cycle pulse
//
// The strobed register port is this design's own decision.
module spcg_core #(
  parameter int N = spcg_pkg::SPCG_PORTS
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [spcg_pkg::SPCG_ADDR_W-1:0] reg_addr,
  input wire logic [spcg_pkg::SPCG_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [spcg_pkg::SPCG_DATA_W-1:0] reg_rdata,
  input wire logic [N-1:0] run_port_gate_reg,
  input wire logic [N-1:0] deepsleep_port_gate_reg,
  input wire logic auto_gating_select,
  input wire logic sleep_req,
  input wire logic deepsleep_req,
  input wire logic [N-1:0] port_access,
  output logic [N-1:0] port_bus_fault,
  output logic [N-1:0] port_clock_enable,
  output logic [N-1:0] port_clock,
  output logic irq
);
  import spcg_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [N-1:0] sleep_port_clock_enables;
  logic [SPCG_EVT_W-1:0] irq_status;
  logic [SPCG_EVT_W-1:0] irq_enable;
  logic [SPCG_EVT_W-1:0] evt_set;
  logic [SPCG_EVT_W-1:0] evt_clr;
  logic [N-1:0] fault_hit;
  logic mode_changed;
  spcg_mode_t mode;
  spcg_mode_t next_mode;
  logic [SPCG_DATA_W-1:0] next_rdata;
  logic wr_gate;
  logic wr_clear;
  logic wr_enable;

  spcg_gate_if #(.N(N)) gif ();

  // ----------------------------------------------------------------
  // register write decode
  // ----------------------------------------------------------------

  // write strobes per register
  assign wr_gate = reg_write && spcg_hit(reg_addr, SPCG_SLEEP_GATE_OFS); // [RULE_08]
  assign wr_clear = reg_write && spcg_hit(reg_addr, SPCG_IRQ_CLEAR_OFS);
  assign wr_enable = reg_write && spcg_hit(reg_addr, SPCG_IRQ_ENABLE_OFS);

  // sleep gate register; only bits 7:0 are kept
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sleep_port_clock_enables <= SPCG_GATE_RESET; // [RULE_03]
    end else if (clk_en && wr_gate) begin
      sleep_port_clock_enables <= reg_wdata[SPCG_GATE_MSB:SPCG_GATE_LSB]; // [RULE_06] [RULE_07]
    end
  end

  // interrupt enable register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_enable <= SPCG_EVT_RESET;
    end else if (clk_en && wr_enable) begin
      irq_enable <= reg_wdata[SPCG_EVT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // power mode tracking
  // ----------------------------------------------------------------

  // deep sleep outranks sleep; no request means running
  always_comb begin
    case (mode)
      SPCG_RUN,
      SPCG_SLEEP,
      SPCG_DEEP: begin
        if (deepsleep_req) begin
          next_mode = SPCG_DEEP;
        end else if (sleep_req) begin
          next_mode = SPCG_SLEEP;
        end else begin
          next_mode = SPCG_RUN;
        end
      end
      default: next_mode = SPCG_RUN;
    endcase
  end

  // mode state register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode <= SPCG_RUN;
    end else if (clk_en) begin
      mode <= next_mode; // [RULE_04]
    end
  end

  assign mode_changed = (next_mode != mode);

  // ----------------------------------------------------------------
  // enable selection and clock gates
  // ----------------------------------------------------------------

  // sources handed to the selector
  assign gif.run_gates = run_port_gate_reg;
  assign gif.sleep_gates = sleep_port_clock_enables;
  assign gif.deep_gates = deepsleep_port_gate_reg;
  assign gif.mode = mode;
  assign gif.auto_sel = auto_gating_select; // [RULE_05]
  assign gif.enables = port_clock_enable;

  spcg_mode_select u_select (
    .gif(gif.sel)
  );

  // applied enables, registered so the gates see a clean level
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      port_clock_enable <= SPCG_GATE_RESET; // [RULE_03]
    end else if (clk_en) begin
      port_clock_enable <= gif.effective; // [RULE_01] [RULE_04]
    end
  end

  spcg_clock_gate_bank #(.N(N)) u_gates (
    .clock(clock),
    .sys_rst(sys_rst),
    .gif(gif.gate)
  );

  assign port_clock = gif.gated_clk; // [RULE_09]

  // ----------------------------------------------------------------
  // bus fault on gated ports
  // ----------------------------------------------------------------

  // access to a port without clock
  assign fault_hit = port_access & ~port_clock_enable; // [RULE_02]

  // one-cycle fault pulse per port
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      port_bus_fault <= '0;
    end else if (clk_en) begin
      port_bus_fault <= fault_hit; // [RULE_02]
    end
  end

  // ----------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------

  // events: per-port faults and power mode change
  always_comb begin
    evt_set = '0;
    evt_set[N-1:0] = fault_hit;
    evt_set[SPCG_EVT_MODE_BIT] = mode_changed;
  end

  // clear mask from the write-only clear register
  assign evt_clr = wr_clear ? reg_wdata[SPCG_EVT_W-1:0] : '0;

  // sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_status <= SPCG_EVT_RESET;
    end else if (clk_en) begin
      irq_status <= (irq_status & ~evt_clr) | evt_set;
    end
  end

  // level interrupt, high while an enabled status bit is set
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(irq_status & irq_enable);
    end
  end

  // ----------------------------------------------------------------
  // register read path
  // ----------------------------------------------------------------

  // read mux; unmapped and write-only addresses read zero
  always_comb begin
    next_rdata = '0;
    if (spcg_hit(reg_addr, SPCG_SLEEP_GATE_OFS)) begin
      next_rdata[SPCG_GATE_MSB:SPCG_GATE_LSB] = sleep_port_clock_enables; // [RULE_07] [RULE_08]
    end else if (spcg_hit(reg_addr, SPCG_IRQ_STATUS_OFS)) begin
      next_rdata[SPCG_EVT_W-1:0] = irq_status;
    end else if (spcg_hit(reg_addr, SPCG_IRQ_ENABLE_OFS)) begin
      next_rdata[SPCG_EVT_W-1:0] = irq_enable;
    end else if (spcg_hit(reg_addr, SPCG_GATE_STATE_OFS)) begin
      next_rdata[SPCG_GATE_MSB:SPCG_GATE_LSB] = port_clock_enable;
      next_rdata[SPCG_STATE_LSB +: 3] = mode;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= SPCG_RDATA_RESET;
    end else if (clk_en) begin
      reg_rdata <= reg_read ? next_rdata : SPCG_RDATA_RESET;
    end
  end

endmodule : spcg_core

// ==== dv/spcg_core_sva.sv ====
// spcg_core_sva: port checks of the sleep port clock gating core
// assumes it is bound to spcg_core, one clock, synchronous reset
module spcg_core_sva import spcg_pkg::*; #(
  parameter int N = 8
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [SPCG_ADDR_W-1:0] reg_addr,
  input wire logic [SPCG_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [SPCG_DATA_W-1:0] reg_rdata,
  input wire logic [N-1:0] run_port_gate_reg,
  input wire logic [N-1:0] deepsleep_port_gate_reg,
  input wire logic auto_gating_select,
  input wire logic sleep_req,
  input wire logic deepsleep_req,
  input wire logic [N-1:0] port_access,
  input wire logic [N-1:0] port_bus_fault,
  input wire logic [N-1:0] port_clock_enable,
  input wire logic [N-1:0] port_clock,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------
  // checks
  // ----------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_reset_clear: assert property (
    $past(sys_rst) |-> reg_rdata == '0 && port_bus_fault == '0 && port_clock_enable == '0 && !irq)
    else $error("outputs not clear after reset");
  a_rdata_idle: assert property (
    $past(clk_en && !reg_read) |-> reg_rdata == '0) else $error("read data outside answer cycle");
  a_gate_readback: assert property (
    $past(clk_en && !sys_rst && reg_write && reg_addr == SPCG_SLEEP_GATE_OFS, 2)
    && $past(clk_en && reg_read && reg_addr == SPCG_SLEEP_GATE_OFS)
    |-> reg_rdata == {24'h000000, $past(reg_wdata[7:0], 2)}) else $error("sleep gate readback");
  a_fault_pulse: assert property (
    $past(clk_en && !sys_rst) |-> port_bus_fault == $past(port_access & ~port_clock_enable))
    else $error("bus fault mismatch");
  a_run_gates: assert property (
    $past(clk_en && !sleep_req && !deepsleep_req, 2) && $past(clk_en && !sys_rst)
    |-> port_clock_enable == $past(run_port_gate_reg)) else $error("run enables not applied");
  a_auto_gate_off: assert property (
    $past(clk_en && !sys_rst && !auto_gating_select) |-> port_clock_enable == $past(run_port_gate_reg))
    else $error("enables without auto gating");
  a_deep_gates: assert property (
    $past(clk_en && !sys_rst && deepsleep_req, 2) && $past(clk_en && !sys_rst && auto_gating_select)
    |-> port_clock_enable == $past(deepsleep_port_gate_reg)) else $error("deep enables not applied");
  a_gate_clock: assert property (@(negedge clock) disable iff (sys_rst)
    port_clock == $past(port_clock_enable)) else $error("gated clock mismatch");
  c_fault: cover property (port_bus_fault != '0);
  c_irq: cover property ($rose(irq));
  c_deep: cover property (deepsleep_req && auto_gating_select ##2 port_clock_enable != '0);
endmodule : spcg_core_sva

bind spcg_core spcg_core_sva #(.N(N)) u_sva (.clock, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_write,
  .reg_read, .reg_rdata, .run_port_gate_reg, .deepsleep_port_gate_reg, .auto_gating_select, .sleep_req,
  .deepsleep_req, .port_access, .port_bus_fault, .port_clock_enable, .port_clock, .irq);

// ==== dv/testbench.sv ====
// testbench: self-checking bench of the sleep port clock gating core
// assumes spcg_pkg, spcg_core and its checker are compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import spcg_pkg::*;
  logic clock = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic auto_sel = 1'b0, slp = 1'b0, dslp = 1'b0, irq, rd_d = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h00000000, reg_rdata, v;
  logic [7:0] run_r = 8'h00, deep_r = 8'h00, acc = 8'h00, fault, pce, pclk, s, e, a;
  logic [31:0] exp_q[$];
  int err_total = 0;
  int compares = 0;

  spcg_core uut (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .run_port_gate_reg(run_r),
    .deepsleep_port_gate_reg(deep_r), .auto_gating_select(auto_sel), .sleep_req(slp), .deepsleep_req(dslp),
    .port_access(acc), .port_bus_fault(fault), .port_clock_enable(pce), .port_clock(pclk), .irq(irq));

  // ----------------
  // helpers
  // ----------------
  initial begin
    forever #4 clock = ~clock;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // one strobe cycle; a read notes its expected answer in d
  task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clock);
    reg_write <= w;
    reg_read <= !w;
    reg_addr <= ad;
    reg_wdata <= d;
    if (!w) exp_q.push_back(d);
    @(posedge clock);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
  endtask : bus

  task automatic test_done;
    $display("mismatches %0d, compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // read answers against the oldest note
  always @(posedge clock) begin
    if (rd_d) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    rd_d <= reg_read && clk_en;
  end

  // hang guard
  initial begin
    repeat (5000) @(posedge clock);
    err_total++;
    test_done();
  end

  // ----------------
  // scenarios
  // ----------------
  initial begin
    v = $urandom(32559);
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    bus(0, SPCG_SLEEP_GATE_OFS, 32'h0);
    bus(0, SPCG_IRQ_STATUS_OFS, 32'h0);
    bus(0, SPCG_IRQ_CLEAR_OFS, 32'h0);
    bus(0, SPCG_GATE_STATE_OFS, 32'h100);
    // write and read back with no gap, reserved bits dropped
    v = $urandom;
    s = v[7:0];
    @(posedge clock);
    reg_addr <= SPCG_SLEEP_GATE_OFS;
    reg_wdata <= v;
    reg_write <= 1'b1;
    exp_q.push_back({24'h000000, s});
    @(posedge clock);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    bus(1, 12'h11C, ~v);
    bus(0, 12'h11C, 32'h0);
    clk_en <= 1'b0;
    bus(1, SPCG_SLEEP_GATE_OFS, 32'h0);
    clk_en <= 1'b1;
    bus(0, SPCG_SLEEP_GATE_OFS, {24'h000000, s});
    // every mode with auto gating off and on
    run_r <= 8'($urandom);
    deep_r <= 8'($urandom);
    for (int i = 0; i < 6; i++) begin
      auto_sel <= i[0];
      slp <= (i / 2 == 1);
      dslp <= (i / 2 == 2);
      repeat (3) @(posedge clock);
      e = (i / 2 == 0 || !i[0]) ? run_r : (i / 2 == 1) ? s : deep_r;
      chk("port_clock_enable", {24'h000000, e}, {24'h000000, pce});
      bus(0, SPCG_GATE_STATE_OFS, {21'h0, 3'b001 << (i / 2), e});
    end
    // fault on a gated port, interrupt raised, masked, cleared
    slp <= 1'b0;
    dslp <= 1'b0;
    run_r <= 8'hFE;
    repeat (3) @(posedge clock);
    // mode changes of the loop left only the mode event set
    bus(0, SPCG_IRQ_STATUS_OFS, 32'h100);
    bus(1, SPCG_IRQ_CLEAR_OFS, 32'h1FF);
    bus(1, SPCG_IRQ_ENABLE_OFS, 32'h1FF);
    bus(0, SPCG_IRQ_ENABLE_OFS, 32'h1FF);
    a = 8'($urandom) | 8'h01;
    @(posedge clock);
    acc <= a;
    @(posedge clock);
    acc <= 8'h00;
    #1 chk("port_bus_fault", 32'h01, {24'h000000, fault});
    // gated clocks follow the clock high phase, quiet in the low phase
    chk("port_clock", 32'hFE, {24'h000000, pclk});
    #4 chk("port_clock", 32'h00, {24'h000000, pclk});
    @(posedge clock);
    #1 chk("irq", 32'h1, {31'h0, irq});
    bus(0, SPCG_IRQ_STATUS_OFS, 32'h001);
    bus(1, SPCG_IRQ_ENABLE_OFS, 32'h0);
    @(posedge clock);
    #1 chk("irq", 32'h0, {31'h0, irq});
    bus(1, SPCG_IRQ_ENABLE_OFS, 32'h1FF);
    bus(1, SPCG_IRQ_CLEAR_OFS, 32'h001);
    @(posedge clock);
    #1 chk("irq", 32'h0, {31'h0, irq});
    repeat (3) @(posedge clock);
    test_done();
  end
endmodule : testbench
